// ### verilog/lpm_pkg.sv
package lpm_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] ACK_OFS    = 8'h08;
	// Control register field positions
	localparam int CTRL_HALT_PERMIT   = 0;
	localparam int CTRL_DEEP_SEL      = 1;
	localparam int CTRL_UV_EN         = 2;
	localparam int CTRL_UV_HALT_EN    = 3;
	localparam int CTRL_DEBUG_EN      = 4;
	localparam int CTRL_WIDTH         = 5;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	// Ack register field
	localparam int ACK_RELEASE        = 0;
	// Status register field positions
	localparam int ST_MODE_LSB        = 0;
	localparam int ST_WAKE_FLAG       = 2;
	localparam int ST_PINS_HELD       = 3;
	localparam int ST_DEBUG           = 4;
	// Debug command codes
	localparam logic [1:0] DBG_HALT_CMD   = 2'h1;
	localparam logic [1:0] DBG_STATUS_CMD = 2'h2;
	localparam logic [1:0] DBG_OTHER_CMD  = 2'h3;
	// Debug answers
	localparam logic [1:0] DBG_ANS_OK     = 2'h0;
	localparam logic [1:0] DBG_ANS_LOWPWR = 2'h1;
	localparam logic [1:0] DBG_ANS_REJECT = 2'h2;
	// Wake sources, one bit each
	localparam int WK_PERIODIC = 0;
	localparam int WK_UV       = 1;
	localparam int WK_CONV     = 2;
	localparam int WK_EXT      = 3;
	localparam int WK_KEYPAD   = 4;
	localparam int WK_WIDTH    = 5;
	typedef enum logic [1:0] {
		LPM_RUN    = 2'b00,
		LPM_IDLE   = 2'b01,
		LPM_DEEP   = 2'b10,
		LPM_RETAIN = 2'b11
	} lpm_mode_e;
endpackage : lpm_pkg

// ### verilog/lpm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module lpm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;

	// Two stages; first stage feeds only the second
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			meta_reg <= '0;
			o_sync   <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule : lpm_sync
`default_nettype wire

// ### verilog/lpm_ctrl.sv
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Idle stops CPU clock, clears interrupt mask
// - Any interrupt ends idle, stacking follows
// - Idle accepts only halt and status commands
// - Status commands in low power report error
// - Debug halt in idle enters debug state
// - Permitted halt stops all internal clocks
// - Unpermitted halt forces illegal opcode reset
// - Deep select chooses deep or retaining halt
// - Undervoltage in halt forces retaining halt
// - Deep halt powers off all but RAM
// - Deep halt latches pins until release
// - Deep halt exits by reset, ext, periodic
// - Ext pin active low in deep halt
// - Deep wake restarts as power-on reset
// - Wake flag set until release written
// - Retaining halt preserves all state
// - Retaining halt exits by reset or sources
// - Internal wake takes source interrupt vector
// - Debug enable keeps debug clock, regulator
// - Debug enable turns deep into retaining
// - Debug halt wakes halt into debug state
module lpm_ctrl (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RESET,
	// AHB-Lite slave
	input  wire logic        I_HSEL,
	input  wire logic [7:0]  I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic [31:0] I_HWDATA,
	input  wire logic        I_HREADY,
	output logic      [31:0] O_HRDATA,
	output logic             O_HREADYOUT,
	output logic             O_HRESP,
	// CPU core
	input  wire logic        I_IDLE_INSN,
	input  wire logic        I_HALT_INSN,
	input  wire logic        I_IRQ_PENDING,
	output logic             O_CPU_CLK_EN,
	output logic             O_CLEAR_IMASK,
	output logic             O_STACK_IRQ,
	output logic             O_ILLEGAL_RESET,
	output logic             O_POR_RESTART,
	output logic             O_TAKE_SRC_VECTOR,
	output logic             O_DEBUG_SUSPEND,
	// Wake pins and sources
	input  wire logic        I_RESET_PIN_N,
	input  wire logic        I_EXT_IRQ_PIN_N,
	input  wire logic [4:0]  I_WAKE_SRC,
	// Power and clock controls
	output logic             O_CLOCKS_EN,
	output logic             O_DEBUG_CLK_EN,
	output logic             O_REG_STANDBY,
	output logic             O_DOMAIN_PWR_EN,
	output logic             O_PIN_LATCH,
	output logic             O_EXT_IRQ_ACTLOW,
	// Debug link command port
	input  wire logic        I_DBG_CMD_VALID,
	input  wire logic [1:0]  I_DBG_CMD,
	output logic             O_DBG_ANS_VALID,
	output logic      [1:0]  O_DBG_ANS
);
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	lpm_pkg::lpm_mode_e mode_reg;
	logic [lpm_pkg::CTRL_WIDTH-1:0] ctrl_reg;
	logic        wake_flag_reg;
	logic        debug_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic        rd_pend_reg;
	logic [7:0]  rd_addr_reg;
	logic [1:0]  pins_sync;
	logic        reset_pin_low;
	logic        ext_pin_low;
	logic        release_pulse;
	logic        halt_ok;
	logic        want_deep;
	logic        retain_wake;
	logic        deep_wake;
	logic        dbg_halt;

	lpm_sync #(.WIDTH(2)) u_sync (
		.i_clk   (I_CORE_CLK),
		.i_reset (I_RESET),
		.i_async ({I_RESET_PIN_N, I_EXT_IRQ_PIN_N}),
		.o_sync  (pins_sync)
	);
	assign reset_pin_low = ~pins_sync[1];
	assign ext_pin_low   = ~pins_sync[0];

	function automatic logic bus_take(input logic [1:0] t, input logic s);
		return I_HSEL && I_HREADY && (t == HTRANS_NONSEQ) &&
		       (s == 1'b1 || s == 1'b0);
	endfunction : bus_take

	// Address phase capture; answers with zero wait states
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rd_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= bus_take(I_HTRANS, I_HWRITE) && I_HWRITE &&
			               (I_HSIZE == HSIZE_WORD);
			rd_pend_reg <= bus_take(I_HTRANS, I_HWRITE) && !I_HWRITE;
			wr_addr_reg <= I_HADDR;
			rd_addr_reg <= I_HADDR;
		end
	end

	assign release_pulse = wr_pend_reg &&
	                       (wr_addr_reg == lpm_pkg::ACK_OFS) &&
	                       I_HWDATA[lpm_pkg::ACK_RELEASE];

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			ctrl_reg <= lpm_pkg::CTRL_RESET;
		end else if (O_POR_RESTART) begin
			ctrl_reg <= lpm_pkg::CTRL_RESET;
		end else if (wr_pend_reg && wr_addr_reg == lpm_pkg::CTRL_OFS) begin
			ctrl_reg <= I_HWDATA[lpm_pkg::CTRL_WIDTH-1:0];
		end
	end

	// Read data registered for the data phase
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			O_HRDATA <= 32'h0000_0000;
		end else if (bus_take(I_HTRANS, I_HWRITE) && !I_HWRITE) begin
			unique case (I_HADDR)
				lpm_pkg::CTRL_OFS:
					O_HRDATA <= {27'h0, ctrl_reg};
				lpm_pkg::STATUS_OFS:
					O_HRDATA <= {27'h0, debug_reg, O_PIN_LATCH,
					             wake_flag_reg, mode_reg};
				default:
					O_HRDATA <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			O_HREADYOUT <= 1'b1;
			O_HRESP     <= 1'b0;
		end else begin
			O_HREADYOUT <= 1'b1;
			O_HRESP     <= 1'b0;
		end
	end

	assign halt_ok   = ctrl_reg[lpm_pkg::CTRL_HALT_PERMIT];
	// Undervoltage or debug overrides force the retaining halt
	assign want_deep = ctrl_reg[lpm_pkg::CTRL_DEEP_SEL] &&
	                   !(ctrl_reg[lpm_pkg::CTRL_UV_EN] &&
	                     ctrl_reg[lpm_pkg::CTRL_UV_HALT_EN]) &&
	                   !ctrl_reg[lpm_pkg::CTRL_DEBUG_EN];
	assign deep_wake = reset_pin_low || ext_pin_low ||
	                   I_WAKE_SRC[lpm_pkg::WK_PERIODIC];
	assign retain_wake = |I_WAKE_SRC || ext_pin_low;
	assign dbg_halt  = I_DBG_CMD_VALID && I_DBG_CMD == lpm_pkg::DBG_HALT_CMD;

	// Mode sequencing
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			mode_reg <= lpm_pkg::LPM_RUN;
		end else begin
			unique case (mode_reg)
				lpm_pkg::LPM_RUN: begin
					if (I_IDLE_INSN && !debug_reg) begin
						mode_reg <= lpm_pkg::LPM_IDLE;
					end else if (I_HALT_INSN && halt_ok && !debug_reg) begin
						mode_reg <= want_deep ? lpm_pkg::LPM_DEEP
						                      : lpm_pkg::LPM_RETAIN;
					end
				end
				lpm_pkg::LPM_IDLE: begin
					if (I_IRQ_PENDING || dbg_halt) begin
						mode_reg <= lpm_pkg::LPM_RUN;
					end
				end
				lpm_pkg::LPM_DEEP: begin
					if (deep_wake) begin
						mode_reg <= lpm_pkg::LPM_RUN;
					end
				end
				lpm_pkg::LPM_RETAIN: begin
					if (reset_pin_low || retain_wake ||
					    (dbg_halt && ctrl_reg[lpm_pkg::CTRL_DEBUG_EN])) begin
						mode_reg <= lpm_pkg::LPM_RUN;
					end
				end
			endcase
		end
	end

	// Strobes to the core, one cycle each
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			O_CLEAR_IMASK     <= 1'b0;
			O_STACK_IRQ       <= 1'b0;
			O_ILLEGAL_RESET   <= 1'b0;
			O_POR_RESTART     <= 1'b0;
			O_TAKE_SRC_VECTOR <= 1'b0;
		end else begin
			O_CLEAR_IMASK   <= mode_reg == lpm_pkg::LPM_RUN && I_IDLE_INSN &&
			                   !debug_reg;
			O_STACK_IRQ     <= mode_reg == lpm_pkg::LPM_IDLE &&
			                   I_IRQ_PENDING && !dbg_halt;
			O_ILLEGAL_RESET <= mode_reg == lpm_pkg::LPM_RUN && I_HALT_INSN &&
			                   !I_IDLE_INSN && !halt_ok && !debug_reg;
			// Reset pin wake also restarts from the reset vector
			O_POR_RESTART   <= (mode_reg == lpm_pkg::LPM_DEEP && deep_wake) ||
			                   (mode_reg == lpm_pkg::LPM_RETAIN &&
			                    reset_pin_low);
			O_TAKE_SRC_VECTOR <= mode_reg == lpm_pkg::LPM_RETAIN &&
			                     !reset_pin_low && retain_wake;
		end
	end

	// Suspended debug state; left when the core runs a restart
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			debug_reg <= 1'b0;
		end else if (O_POR_RESTART) begin
			debug_reg <= 1'b0;
		end else if (mode_reg == lpm_pkg::LPM_IDLE && dbg_halt) begin
			debug_reg <= 1'b1;
		end else if (mode_reg == lpm_pkg::LPM_RETAIN && dbg_halt &&
		             ctrl_reg[lpm_pkg::CTRL_DEBUG_EN] && !reset_pin_low) begin
			debug_reg <= 1'b1;
		end else if (mode_reg == lpm_pkg::LPM_RUN && dbg_halt) begin
			debug_reg <= 1'b1;
		end
	end

	// Pin latch and wake flag; a new latch wins over a release
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			O_PIN_LATCH   <= 1'b0;
			wake_flag_reg <= 1'b0;
		end else begin
			if (mode_reg == lpm_pkg::LPM_RUN && I_HALT_INSN && halt_ok &&
			    want_deep && !I_IDLE_INSN && !debug_reg) begin
				O_PIN_LATCH <= 1'b1;
			end else if (release_pulse) begin
				O_PIN_LATCH <= 1'b0;
			end
			if (mode_reg == lpm_pkg::LPM_DEEP && deep_wake) begin
				wake_flag_reg <= 1'b1;
			end else if (release_pulse) begin
				wake_flag_reg <= 1'b0;
			end
		end
	end

	// Clock and power controls follow the mode
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			O_CPU_CLK_EN     <= 1'b1;
			O_CLOCKS_EN      <= 1'b1;
			O_DEBUG_CLK_EN   <= 1'b1;
			O_REG_STANDBY    <= 1'b0;
			O_DOMAIN_PWR_EN  <= 1'b1;
			O_EXT_IRQ_ACTLOW <= 1'b0;
			O_DEBUG_SUSPEND  <= 1'b0;
		end else begin
			O_CPU_CLK_EN     <= mode_reg == lpm_pkg::LPM_RUN;
			O_CLOCKS_EN      <= mode_reg == lpm_pkg::LPM_RUN ||
			                    mode_reg == lpm_pkg::LPM_IDLE;
			O_DEBUG_CLK_EN   <= mode_reg == lpm_pkg::LPM_RUN ||
			                    mode_reg == lpm_pkg::LPM_IDLE ||
			                    ctrl_reg[lpm_pkg::CTRL_DEBUG_EN];
			O_REG_STANDBY    <= (mode_reg == lpm_pkg::LPM_DEEP) ||
			                    (mode_reg == lpm_pkg::LPM_RETAIN &&
			                     !ctrl_reg[lpm_pkg::CTRL_DEBUG_EN] &&
			                     !(ctrl_reg[lpm_pkg::CTRL_UV_EN] &&
			                       ctrl_reg[lpm_pkg::CTRL_UV_HALT_EN]));
			O_DOMAIN_PWR_EN  <= mode_reg != lpm_pkg::LPM_DEEP;
			O_EXT_IRQ_ACTLOW <= mode_reg == lpm_pkg::LPM_DEEP;
			O_DEBUG_SUSPEND  <= debug_reg;
		end
	end

	// Debug link filter
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			O_DBG_ANS_VALID <= 1'b0;
			O_DBG_ANS       <= lpm_pkg::DBG_ANS_OK;
		end else begin
			O_DBG_ANS_VALID <= I_DBG_CMD_VALID;
			if (!I_DBG_CMD_VALID || mode_reg == lpm_pkg::LPM_RUN) begin
				O_DBG_ANS <= lpm_pkg::DBG_ANS_OK;
			end else if (I_DBG_CMD == lpm_pkg::DBG_STATUS_CMD) begin
				O_DBG_ANS <= lpm_pkg::DBG_ANS_LOWPWR;
			end else if (I_DBG_CMD == lpm_pkg::DBG_HALT_CMD &&
			             (mode_reg == lpm_pkg::LPM_IDLE ||
			              ctrl_reg[lpm_pkg::CTRL_DEBUG_EN])) begin
				O_DBG_ANS <= lpm_pkg::DBG_ANS_OK;
			end else begin
				O_DBG_ANS <= lpm_pkg::DBG_ANS_REJECT;
			end
		end
	end
endmodule : lpm_ctrl
`default_nettype wire

// ### sim/lpm_ctrl_props.sv
`timescale 1ns/10ps
`default_nettype none
module lpm_ctrl_chk (
	input wire logic       I_CORE_CLK,
	input wire logic       I_RESET,
	input wire logic       I_DBG_CMD_VALID,
	input wire logic [1:0] I_DBG_CMD,
	input wire logic       O_DBG_ANS_VALID,
	input wire logic [1:0] O_DBG_ANS,
	input wire logic       O_CPU_CLK_EN,
	input wire logic       O_CLOCKS_EN,
	input wire logic       O_DEBUG_CLK_EN,
	input wire logic       O_REG_STANDBY,
	input wire logic       O_DOMAIN_PWR_EN,
	input wire logic       O_PIN_LATCH,
	input wire logic       O_EXT_IRQ_ACTLOW,
	input wire logic       O_DEBUG_SUSPEND,
	input wire logic       O_CLEAR_IMASK,
	input wire logic       O_STACK_IRQ,
	input wire logic       O_ILLEGAL_RESET
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RESET);
	a_idle_cpu_stop: assert property (O_CLEAR_IMASK |=> !O_CPU_CLK_EN)
		else $error("cpu clock on after idle entry");
	a_irq_resume: assert property (O_STACK_IRQ |=> O_CPU_CLK_EN)
		else $error("cpu clock off after interrupt exit");
	a_dbg_answer: assert property (I_DBG_CMD_VALID |=> O_DBG_ANS_VALID)
		else $error("debug command not answered");
	// Two low cycles so a wake in flight is not mistaken for low power
	a_other_reject: assert property ((I_DBG_CMD_VALID && !O_DEBUG_SUSPEND
		&& I_DBG_CMD == lpm_pkg::DBG_OTHER_CMD && !O_CPU_CLK_EN)
		##1 !O_CPU_CLK_EN |-> O_DBG_ANS == lpm_pkg::DBG_ANS_REJECT)
		else $error("other command accepted in low power");
	a_status_error: assert property ((I_DBG_CMD_VALID && !O_DEBUG_SUSPEND
		&& I_DBG_CMD == lpm_pkg::DBG_STATUS_CMD && !O_CPU_CLK_EN)
		##1 !O_CPU_CLK_EN |-> O_DBG_ANS == lpm_pkg::DBG_ANS_LOWPWR)
		else $error("status command without low power error");
	a_idle_dbg_halt: assert property ((I_DBG_CMD_VALID && !O_DEBUG_SUSPEND
		&& I_DBG_CMD == lpm_pkg::DBG_HALT_CMD && !O_CPU_CLK_EN && O_CLOCKS_EN)
		##1 (!O_CPU_CLK_EN && O_CLOCKS_EN)
		|-> O_DBG_ANS == lpm_pkg::DBG_ANS_OK ##[0:2] O_DEBUG_SUSPEND)
		else $error("debug halt in idle did not suspend");
	a_deep_power: assert property (!O_DOMAIN_PWR_EN |-> O_REG_STANDBY
		&& !O_CLOCKS_EN && O_PIN_LATCH && O_EXT_IRQ_ACTLOW && !O_DEBUG_CLK_EN)
		else $error("deep halt power state wrong");
	a_illegal_run: assert property (O_ILLEGAL_RESET |-> O_CPU_CLK_EN
		&& O_CLOCKS_EN ##1 O_CLOCKS_EN)
		else $error("clocks stopped on refused halt");
endmodule : lpm_ctrl_chk
bind lpm_ctrl lpm_ctrl_chk u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET),
	.I_DBG_CMD_VALID(I_DBG_CMD_VALID), .I_DBG_CMD(I_DBG_CMD),
	.O_DBG_ANS_VALID(O_DBG_ANS_VALID), .O_DBG_ANS(O_DBG_ANS),
	.O_CPU_CLK_EN(O_CPU_CLK_EN), .O_CLOCKS_EN(O_CLOCKS_EN),
	.O_DEBUG_CLK_EN(O_DEBUG_CLK_EN), .O_REG_STANDBY(O_REG_STANDBY),
	.O_DOMAIN_PWR_EN(O_DOMAIN_PWR_EN), .O_PIN_LATCH(O_PIN_LATCH),
	.O_EXT_IRQ_ACTLOW(O_EXT_IRQ_ACTLOW), .O_DEBUG_SUSPEND(O_DEBUG_SUSPEND),
	.O_CLEAR_IMASK(O_CLEAR_IMASK), .O_STACK_IRQ(O_STACK_IRQ),
	.O_ILLEGAL_RESET(O_ILLEGAL_RESET));
`default_nettype wire

// ### sim/lpm_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module lpm_core_model (
	input  wire logic       i_clk,
	input  wire logic       i_ans_valid,
	input  wire logic [1:0] i_ans,
	output var logic        o_idle,
	output var logic        o_halt,
	output var logic        o_irq,
	output var logic        o_dbg_valid,
	output var logic [1:0]  o_dbg_cmd
);
	initial begin
		o_idle = 1'b0;
		o_halt = 1'b0;
		o_irq = 1'b0;
		o_dbg_valid = 1'b0;
		o_dbg_cmd = 2'h0;
	end
	task automatic insn(input logic idle, input logic halt);
		@(posedge i_clk);
		o_idle <= idle;
		o_halt <= halt;
		@(posedge i_clk);
		o_idle <= 1'b0;
		o_halt <= 1'b0;
	endtask : insn
	task automatic irq();
		@(posedge i_clk);
		o_irq <= 1'b1;
		repeat (2) @(posedge i_clk);
		o_irq <= 1'b0;
	endtask : irq
	task automatic dbg(input logic [1:0] cmd, output logic [1:0] ans);
		ans = 2'h3;
		@(posedge i_clk);
		o_dbg_valid <= 1'b1;
		o_dbg_cmd <= cmd;
		@(posedge i_clk);
		o_dbg_valid <= 1'b0;
		// Stale code would hide a decoder that ignores valid
		o_dbg_cmd <= ~cmd;
		repeat (3) begin
			@(negedge i_clk);
			if (i_ans_valid === 1'b1)
				ans = i_ans;
		end
	endtask : dbg
endmodule : lpm_core_model
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk, rst, hsel, hwrite, rdy, resp, rpin_n, ext_n;
	logic        idle, halt, irq, dv, av, cpu, clks, dclk, stby, dom;
	logic        latch, actlow, susp, clr, stk, ill, por, srcv;
	logic [7:0]  haddr, pw;
	logic [1:0]  htrans, dc, ans, a;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, st;
	logic [4:0]  wake, seen;
	logic        seen_clr;
	int          failures, tests_run;
	assign pw = {cpu, clks, dclk, stby, dom, latch, actlow, susp};
	lpm_ctrl DUT (.I_CORE_CLK(clk), .I_RESET(rst), .I_HSEL(hsel),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
		.I_HWDATA(hwdata), .I_HREADY(rdy), .O_HRDATA(hrdata),
		.O_HREADYOUT(rdy), .O_HRESP(resp), .I_IDLE_INSN(idle),
		.I_HALT_INSN(halt), .I_IRQ_PENDING(irq), .O_CPU_CLK_EN(cpu),
		.O_CLEAR_IMASK(clr), .O_STACK_IRQ(stk), .O_ILLEGAL_RESET(ill),
		.O_POR_RESTART(por), .O_TAKE_SRC_VECTOR(srcv),
		.O_DEBUG_SUSPEND(susp), .I_RESET_PIN_N(rpin_n),
		.I_EXT_IRQ_PIN_N(ext_n), .I_WAKE_SRC(wake), .O_CLOCKS_EN(clks),
		.O_DEBUG_CLK_EN(dclk), .O_REG_STANDBY(stby), .O_DOMAIN_PWR_EN(dom),
		.O_PIN_LATCH(latch), .O_EXT_IRQ_ACTLOW(actlow),
		.I_DBG_CMD_VALID(dv), .I_DBG_CMD(dc), .O_DBG_ANS_VALID(av),
		.O_DBG_ANS(ans));
	lpm_core_model core (.i_clk(clk), .i_ans_valid(av), .i_ans(ans),
		.o_idle(idle), .o_halt(halt), .o_irq(irq), .o_dbg_valid(dv),
		.o_dbg_cmd(dc));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// One driver for the pulse record; the bench only requests a clear
	always @(posedge clk) begin
		if (seen_clr)
			seen <= 5'h00;
		else
			seen <= seen | {srcv, por, ill, stk, clr};
	end
	task automatic summarize();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic ahb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= ad;
		hwrite <= w;
		do @(posedge clk); while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		st = hrdata;
		hsel <= 1'b0;
	endtask : ahb
	task automatic rc(input string n, input logic [7:0] ad, input logic [31:0] e);
		ahb(1'b0, ad, 32'h0);
		chk(n, e, st);
		chk("resp", 32'h0, {31'h0, resp});
	endtask : rc
	task automatic pc(input logic [7:0] m, e);
		@(negedge clk);
		chk("power", {24'h0, e}, {24'h0, pw & m});
	endtask : pc
	task automatic sc(input logic [4:0] e);
		chk("pulses", {27'h0, e}, {27'h0, seen});
		@(negedge clk);
		seen_clr = 1'b1;
		@(negedge clk);
		seen_clr = 1'b0;
	endtask : sc
	task automatic dq(input logic [1:0] c, e);
		core.dbg(c, a);
		chk("answer", {30'h0, e}, {30'h0, a});
	endtask : dq
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		summarize();
	end
	initial begin
		{rst, rpin_n, ext_n} = 3'b111;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		{wake, failures, tests_run} = '0;
		seen_clr = 1'b1;
		hsize = 3'h2;
		wt(20);
		rst <= 1'b0;
		seen_clr = 1'b0;
		rc("ctrl", 8'h00, 32'h0);
		rc("status", 8'h04, 32'h0);
		rc("unmapped", 8'h0c, 32'h0);
		pc(8'hff, 8'he8);
		ahb(1'b1, 8'h00, 32'h1f);
		rc("ctrl", 8'h00, 32'h1f);
		rc("ack", 8'h08, 32'h0);
		ahb(1'b1, 8'h00, 32'h0);
		core.insn(1'b1, 1'b0);
		wt(3);
		rc("status", 8'h04, 32'h1);
		pc(8'h80, 8'h00);
		dq(lpm_pkg::DBG_OTHER_CMD, lpm_pkg::DBG_ANS_REJECT);
		dq(lpm_pkg::DBG_STATUS_CMD, lpm_pkg::DBG_ANS_LOWPWR);
		sc(5'h01);
		core.irq();
		wt(3);
		rc("status", 8'h04, 32'h0);
		pc(8'h80, 8'h80);
		sc(5'h02);
		core.insn(1'b0, 1'b1);
		wt(3);
		rc("status", 8'h04, 32'h0);
		sc(5'h04);
		ahb(1'b1, 8'h00, 32'h03);
		core.insn(1'b0, 1'b1);
		wt(4);
		pc(8'hff, 8'h16);
		// Sources that only wake the retaining halt
		wake <= 5'h16;
		wt(8);
		pc(8'h08, 8'h00);
		wake <= 5'h0;
		ext_n <= 1'b0;
		wt(8);
		ext_n <= 1'b1;
		sc(5'h08);
		rc("status", 8'h04, 32'h0c);
		rc("ctrl", 8'h00, 32'h0);
		pc(8'hff, 8'hec);
		ahb(1'b1, 8'h00, 32'h0f);
		ahb(1'b1, 8'h08, 32'h0);
		rc("status", 8'h04, 32'h0c);
		ahb(1'b1, 8'h08, 32'h1);
		rc("status", 8'h04, 32'h0);
		pc(8'h04, 8'h00);
		for (int i = 0; i < 5; i++) begin
			core.insn(1'b0, 1'b1);
			wt(4);
			rc("status", 8'h04, 32'h3);
			pc(8'hc8, 8'h08);
			if (i == 0) begin
				dq(lpm_pkg::DBG_STATUS_CMD, lpm_pkg::DBG_ANS_LOWPWR);
				dq(lpm_pkg::DBG_HALT_CMD, lpm_pkg::DBG_ANS_REJECT);
			end
			wake <= 5'(1 << i);
			wt(3);
			wake <= 5'h0;
			wt(3);
			rc("status", 8'h04, 32'h0);
			sc(5'h10);
		end
		rc("ctrl", 8'h00, 32'h0f);
		core.insn(1'b0, 1'b1);
		wt(4);
		rpin_n <= 1'b0;
		wt(6);
		rpin_n <= 1'b1;
		wt(6);
		sc(5'h08);
		rc("status", 8'h04, 32'h0);
		ahb(1'b1, 8'h00, 32'h13);
		core.insn(1'b0, 1'b1);
		wt(4);
		rc("status", 8'h04, 32'h3);
		pc(8'hf8, 8'h28);
		dq(lpm_pkg::DBG_HALT_CMD, lpm_pkg::DBG_ANS_OK);
		pc(8'h01, 8'h01);
		dq(lpm_pkg::DBG_OTHER_CMD, lpm_pkg::DBG_ANS_OK);
		@(posedge clk);
		rst <= 1'b1;
		wt(20);
		rst <= 1'b0;
		pc(8'h01, 8'h00);
		core.insn(1'b1, 1'b0);
		wt(3);
		dq(lpm_pkg::DBG_HALT_CMD, lpm_pkg::DBG_ANS_OK);
		pc(8'h01, 8'h01);
		summarize();
	end
endmodule : tb
`default_nettype wire
